// ---- dsc_scaler_ctrl.sv ----
// Display pipe scaler control: registers, double buffer, binding and pixel path
// How it works
// - Window size write arms; vblank start applies.
// - Bit 31 enables scaling.
// - Bit 28 enables adaptive filtering; thresholds loaded.
// - Bits 27:25 bind pipe or planes 1-5.
// - Input size from pipe or bound plane.
// - Uncovered plane border delivered fully transparent.
// - Bits 24:23 pick medium/programmed/edge/bilinear.
// - Medium at 1:1 with bit 28 clear passes image unfiltered.
// - Bit 22 picks adaptive coefficients, else ignored.
// - Bit 21 selects linear or non-linear tap.
// - Plane path 10-bit colour unless bypassed, pipe 12-bit.
// - Two independent scaler instances per pipe.
// - Attach to non-cursor plane or pipe output.
// - Accept sources to 5120 wide, 4096 high.
// - Pipe width adds left and right seam.
// - Coefficient index 0-59, optional auto-increment.
`include "dsc_params.svh"
module dsc_scaler_ctrl #(
  parameter logic [19:0] BASE_ADDR = `DSC_BASE_A1,
  parameter int MAX_W = `DSC_MAX_W,
  parameter int MAX_H = `DSC_MAX_H,
  parameter int COEF_N = `DSC_COEF_N,
  parameter int FIFO_DEPTH = `DSC_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [19:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic vblank_i,
  input wire logic [12:0] trans_hactive_i,
  input wire logic [12:0] seam_left_i,
  input wire logic [12:0] seam_right_i,
  input wire logic [12:0] pipe_src_h_i,
  input wire dsc_pkg::dsc_size_t plane_size_i [5],
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire dsc_pkg::dsc_pix_t pix_i,
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  output dsc_pkg::dsc_pix_t pix_o,
  output dsc_pkg::dsc_cfg_t cfg_o,
  output logic [31:0] coef_o
);
  import dsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  wire sel_ctrl = reg_addr_i == BASE_ADDR + `DSC_REL_CTRL;
  wire sel_cidx = reg_addr_i == BASE_ADDR + `DSC_REL_CIDX;
  wire sel_cdat = reg_addr_i == BASE_ADDR + `DSC_REL_CDAT;
  wire sel_thr = reg_addr_i == BASE_ADDR + `DSC_REL_THR;
  wire sel_win = reg_addr_i == BASE_ADDR + `DSC_REL_WIN;
  wire sel_stat = reg_addr_i == BASE_ADDR + `DSC_REL_STAT;
  wire wr_ctrl = reg_wr_i & sel_ctrl;
  wire wr_thr = reg_wr_i & sel_thr;
  wire wr_win = reg_wr_i & sel_win;
  wire wr_cidx = reg_wr_i & sel_cidx;
  wire wr_cdat = reg_wr_i & sel_cdat;
  wire cdat_access = (reg_wr_i | reg_rd_i) & sel_cdat;

  ////////////////////////////////////////////////////////////////////////
  // Staged and active copies
  logic [31:0] ctrl_r;
  logic [31:0] thr_r;
  logic [31:0] win_r;
  logic [31:0] ctrl_a_r;
  logic [31:0] thr_a_r;
  logic [31:0] win_a_r;
  logic armed_r;
  logic vblank_q_r;
  wire vb_start = vblank_i & ~vblank_q_r;
  wire apply = vb_start & armed_r;
  // A window write in the same cycle as vblank start arms the next frame
  wire armed_nxt = wr_win | (armed_r & ~vb_start);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `DSC_CTRL_RST;
      thr_r <= '0;
      win_r <= '0;
      armed_r <= 1'b0;
      vblank_q_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata_i & `DSC_CTRL_MASK;
      if (wr_thr) thr_r <= reg_wdata_i & `DSC_THR_MASK;
      if (wr_win) win_r <= reg_wdata_i & `DSC_WIN_MASK;
      armed_r <= armed_nxt;
      vblank_q_r <= vblank_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_r <= `DSC_CTRL_RST;
      thr_a_r <= '0;
      win_a_r <= '0;
    end else if (apply) begin
      ctrl_a_r <= ctrl_r;
      thr_a_r <= thr_r;
      win_a_r <= win_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Coefficient array; not reset, software loads it before use
  logic [31:0] coef_mem [COEF_N];
  logic [5:0] cidx_r;
  logic autoinc_r;
  wire cidx_ok = cidx_r <= `DSC_COEF_LAST;
  wire [5:0] cidx_nxt = (cidx_r >= `DSC_COEF_LAST) ? '0 : cidx_r + 6'h1;
  assign coef_o = cidx_ok ? coef_mem[cidx_r] : '0;

  always_ff @(posedge clk_i) begin
    if (wr_cdat && cidx_ok) begin
      coef_mem[cidx_r] <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cidx_r <= '0;
      autoinc_r <= 1'b1;
    end else if (wr_cidx) begin
      cidx_r <= reg_wdata_i[`DSC_F_CIDX];
      autoinc_r <= reg_wdata_i[`DSC_B_AUTOINC];
    end else if (cdat_access && autoinc_r) begin
      cidx_r <= cidx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective configuration
  wire en = ctrl_a_r[`DSC_B_EN];
  wire adapt = ctrl_a_r[`DSC_B_ADAPT];
  wire [2:0] bind_sel = ctrl_a_r[`DSC_F_BIND];
  wire [1:0] filt = ctrl_a_r[`DSC_F_FILT];
  wire afsel = ctrl_a_r[`DSC_B_AFSEL];
  wire tap = ctrl_a_r[`DSC_B_TAP];
  wire bind_ok = bind_sel <= `DSC_BIND_LAST;
  wire bind_plane = bind_sel != `DSC_BIND_PIPE;
  wire [12:0] pipe_w = 13'(trans_hactive_i + seam_left_i + seam_right_i);
  wire [2:0] plane_idx = bind_ok && bind_plane ? bind_sel - 3'h1 : 3'h0;
  dsc_size_t in_sz;
  dsc_size_t win_sz;
  assign in_sz = bind_plane ? plane_size_i[plane_idx] : '{w: pipe_w, h: pipe_src_h_i};
  assign win_sz = '{w: win_a_r[`DSC_F_WIN_W], h: win_a_r[`DSC_F_WIN_H]};
  wire size_ok = (in_sz.w <= 13'(MAX_W)) && (in_sz.h <= 13'(MAX_H));
  wire scale_on = en & bind_ok & size_ok;
  wire unity = (in_sz.w == win_sz.w) && (in_sz.h == win_sz.h);
  wire medium_unity = (dsc_filt_t'(filt) == DSC_MEDIUM) & unity & ~adapt;
  wire passthru = ~scale_on | medium_unity;
  // Adaptive select only matters while adaptive filtering is on
  dsc_filt_t coef_eff;
  assign coef_eff = adapt ? (afsel ? DSC_EDGE : DSC_MEDIUM) : dsc_filt_t'(filt);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o <= '{active: scale_on, passthru: passthru, adaptive: adapt & scale_on,
                 tap_linear: tap, binding: bind_sel, coef: coef_eff,
                 in_size: in_sz, win_size: win_sz, thresholds: thr_a_r[`DSC_F_THR]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel path: position tracking, border alpha and precision
  logic [12:0] x_r;
  logic [12:0] y_r;
  logic fifo_ready;
  wire take = pix_valid_i & fifo_ready;
  wire [12:0] cur_x = pix_i.sof ? '0 : x_r;
  wire [12:0] cur_y = pix_i.sof ? '0 : y_r;
  wire outside = (cur_x >= win_sz.w) | (cur_y >= win_sz.h);
  wire border = scale_on & bind_plane & outside;
  wire trunc = ~passthru & bind_plane;
  wire [11:0] lo_mask = trunc ? 12'hffc : 12'hfff;
  dsc_pix_t pix_w;
  assign pix_w = '{sof: pix_i.sof, eol: pix_i.eol,
                   a: border ? 8'h00 : pix_i.a,
                   r: pix_i.r & lo_mask, g: pix_i.g & lo_mask, b: pix_i.b & lo_mask};
  assign pix_ready_o = fifo_ready;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x_r <= '0;
      y_r <= '0;
    end else if (take) begin
      x_r <= pix_i.eol ? '0 : cur_x + 13'h1;
      y_r <= pix_i.eol ? cur_y + 13'h1 : cur_y;
    end
  end

  // Back-pressure from the blender reaches the fetch side through the FIFO
  dsc_fifo #(
    .WIDTH($bits(dsc_pix_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(fifo_ready),
    .in_data_i(pix_w),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i),
    .out_data_o(pix_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read-back
  wire [31:0] stat_w = {scale_on, armed_r, size_ok, passthru, bind_sel, 2'(coef_eff),
                        10'h000, 13'(in_sz.w)};
  wire [31:0] rd_w = sel_ctrl ? ctrl_r :
                     sel_thr ? thr_r :
                     sel_win ? win_r :
                     sel_cidx ? {21'h0, autoinc_r, 4'h0, cidx_r} :
                     sel_cdat ? coef_o :
                     sel_stat ? stat_w : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
      reg_ack_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_w : '0;
      reg_ack_o <= reg_rd_i | reg_wr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_arm_hold;
    @(posedge clk_i) disable iff (rst_i) armed_r && !vb_start |=> armed_r;
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("arm lost");

  property p_apply;
    @(posedge clk_i) disable iff (rst_i)
      vb_start && armed_r |=> ctrl_a_r == $past(ctrl_r) && armed_r == $past(wr_win);
  endproperty
  a_apply: assert property (p_apply) else $error("staged value not applied");

  property p_hold_unarmed;
    @(posedge clk_i) disable iff (rst_i) !armed_r |=> $stable(ctrl_a_r) && $stable(win_a_r);
  endproperty
  a_hold_unarmed: assert property (p_hold_unarmed) else $error("update unarmed");

  property p_disabled_pass;
    @(posedge clk_i) disable iff (rst_i) take && !en |-> pix_w == pix_i;
  endproperty
  a_disabled_pass: assert property (p_disabled_pass) else $error("disabled altered");

  property p_border;
    @(posedge clk_i) disable iff (rst_i)
      take && en && bind_plane && bind_ok && size_ok && outside |-> pix_w.a == 8'h00;
  endproperty
  a_border: assert property (p_border) else $error("border not transparent");

  property p_idx_wrap;
    @(posedge clk_i) disable iff (rst_i)
      cdat_access && autoinc_r && !wr_cidx && cidx_r == `DSC_COEF_LAST |=> cidx_r == '0;
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("index did not wrap");

  property p_idx_inc;
    @(posedge clk_i) disable iff (rst_i)
      cdat_access && autoinc_r && !wr_cidx && cidx_r < `DSC_COEF_LAST
      |=> cidx_r == $past(cidx_r) + 6'h1;
  endproperty
  a_idx_inc: assert property (p_idx_inc) else $error("index did not advance");

  property p_size_limit;
    @(posedge clk_i) disable iff (rst_i)
      en && bind_ok && in_sz.w <= 13'(MAX_W) && in_sz.h <= 13'(MAX_H) |=> cfg_o.active;
  endproperty
  a_size_limit: assert property (p_size_limit) else $error("legal size refused");

  property p_adapt_sel;
    @(posedge clk_i) disable iff (rst_i)
      adapt && afsel |-> coef_eff == DSC_EDGE;
  endproperty
  a_adapt_sel: assert property (p_adapt_sel) else $error("adaptive select wrong");

  property p_unity;
    @(posedge clk_i) disable iff (rst_i)
      scale_on && medium_unity |=> cfg_o.passthru && cfg_o.coef == DSC_MEDIUM;
  endproperty
  a_unity: assert property (p_unity) else $error("1:1 medium not bypassed");
endmodule // dsc_scaler_ctrl

// ---- dsc_params.svh ----
// Constants for the display scaler control block: offsets, fields, limits
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
`define DSC_BASE_A1 20'h68180
`define DSC_BASE_A2 20'h68280
`define DSC_BASE_B1 20'h68980
`define DSC_BASE_B2 20'h68a80
`define DSC_BASE_C1 20'h69180
`define DSC_BASE_C2 20'h69280
`define DSC_REL_CTRL 20'h00000
`define DSC_REL_CIDX 20'h00018
`define DSC_REL_CDAT 20'h0001c
`define DSC_REL_THR 20'h00028
`define DSC_REL_WIN 20'h00074
`define DSC_REL_STAT 20'h00078
`define DSC_CTRL_RST 32'h0000_0200
`define DSC_CTRL_MASK 32'hdffa_b31e
`define DSC_THR_MASK 32'h00ff_ffff
`define DSC_WIN_MASK 32'h1fff_1fff
`define DSC_B_EN 31
`define DSC_B_ADAPT 28
`define DSC_F_BIND 27:25
`define DSC_F_FILT 24:23
`define DSC_B_AFSEL 22
`define DSC_B_TAP 21
`define DSC_F_WIN_W 28:16
`define DSC_F_WIN_H 12:0
`define DSC_F_THR 23:0
`define DSC_F_CIDX 5:0
`define DSC_B_AUTOINC 10
`define DSC_BIND_PIPE 3'h0
`define DSC_BIND_LAST 3'h5
`define DSC_MAX_W 5120
`define DSC_MAX_H 4096
`define DSC_COEF_N 60
`define DSC_COEF_LAST 6'h3b
`define DSC_FIFO_DEPTH 8
`define DSC_LOW_DROP 2
`endif

// ---- dsc_pkg.sv ----
// Types shared by the display scaler control block
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_MEDIUM = 2'h0,
    DSC_PROGRAMMED = 2'h1,
    DSC_EDGE = 2'h2,
    DSC_BILINEAR = 2'h3
  } dsc_filt_t;
  typedef struct packed {
    logic [12:0] w;
    logic [12:0] h;
  } dsc_size_t;
  typedef struct packed {
    logic sof;
    logic eol;
    logic [7:0] a;
    logic [11:0] r;
    logic [11:0] g;
    logic [11:0] b;
  } dsc_pix_t;
  typedef struct packed {
    logic active;
    logic passthru;
    logic adaptive;
    logic tap_linear;
    logic [2:0] binding;
    dsc_filt_t coef;
    dsc_size_t in_size;
    dsc_size_t win_size;
    logic [23:0] thresholds;
  } dsc_cfg_t;
endpackage

// ---- dsc_fifo.sv ----
// Parameterised valid/ready FIFO for the scaler pixel path
module dsc_fifo #(
  parameter int WIDTH = 46,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem[rp_r];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dsc_fifo

// ---- dsc_far_side.sv ----
// Far-side model: plane fetch source and blender sink for the scaler pixel path
module dsc_far_side (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic stall_i,
  input wire logic [12:0] w_i,
  input wire logic [12:0] h_i,
  input wire logic take_ready_i,
  output logic valid_o,
  output dsc_pkg::dsc_pix_t pix_o,
  output logic sink_ready_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsc_pkg::*;
  logic took;
  logic [12:0] x;
  logic [12:0] y;
  // Handshake seen at the rising edge, acted on at the falling edge
  always @(posedge clk_i) took <= valid_o && take_ready_i;
  always @(negedge clk_i) begin
    sink_ready_o <= !stall_i && ($urandom % 4 != 0);
    if (rst_i || !go_i) begin
      valid_o <= 1'b0;
      done_o <= 1'b0;
      x = '0;
      y = '0;
    end else if (!done_o && (took || !valid_o)) begin
      if (took) begin
        x = x + 13'h1;
        if (x == w_i) begin
          x = '0;
          y = y + 13'h1;
        end
      end
      if (y == h_i) begin
        done_o <= 1'b1;
        valid_o <= 1'b0;
        pix_o <= ~pix_o;
      end else if ($urandom % 3 == 0) begin
        // Slow answer: the lines no longer hold the last pixel
        valid_o <= 1'b0;
        pix_o <= ~pix_o;
      end else begin
        valid_o <= 1'b1;
        pix_o <= {x == 0 && y == 0, x == w_i - 13'h1,
                  8'($urandom), 36'({$urandom, $urandom})};
      end
    end
  end
endmodule // dsc_far_side

// ---- display_pipe_scaler_control_bench.sv ----
// Self-checking bench for the display scaler control block
`include "dsc_params.svh"
module display_pipe_scaler_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsc_pkg::*;
  logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, vblank_i = 0, go = 0, stall = 0;
  logic [19:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, reg_rdata_o, coef_o, q, ctl, rdata2;
  logic [12:0] trans_hactive_i = 13'h4, seam_left_i = 13'h3, seam_right_i = 13'h1;
  logic [12:0] pipe_src_h_i = 13'h8, fw = 13'h8, fh = 13'h8, ww, wh;
  dsc_size_t plane_size_i [5];
  logic pix_valid_i, pix_ready_o, pix_valid_o, pix_ready_i, done, reg_ack_o;
  dsc_pix_t pix_i, pix_o;
  dsc_cfg_t cfg_o;
  int n_errors = 0, total_checks = 0, ix, iy, inflight = 0;
  dsc_pix_t expq [$];
  logic [31:0] fc [4] = '{32'h8500_0000, 32'h8000_0000, 32'h0380_0000, 32'h81a0_0000};
  dsc_scaler_ctrl DUT (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .reg_ack_o, .vblank_i, .trans_hactive_i, .seam_left_i, .seam_right_i,
    .pipe_src_h_i, .plane_size_i, .pix_valid_i, .pix_ready_o, .pix_i, .pix_valid_o,
    .pix_ready_i, .pix_o, .cfg_o, .coef_o);
  // Second scaler of the pipe shares the bus; only its read data is watched
  dsc_scaler_ctrl #(.BASE_ADDR(`DSC_BASE_A2)) DUT2 (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o(rdata2), .reg_ack_o(), .vblank_i, .trans_hactive_i,
    .seam_left_i, .seam_right_i, .pipe_src_h_i, .plane_size_i, .pix_valid_i(1'b0),
    .pix_ready_o(), .pix_i, .pix_valid_o(), .pix_ready_i(1'b1), .pix_o(), .cfg_o(), .coef_o());
  dsc_far_side FAR (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .stall_i(stall), .w_i(fw),
    .h_i(fh), .take_ready_i(pix_ready_o), .valid_o(pix_valid_i), .pix_o(pix_i),
    .sink_ready_o(pix_ready_i), .done_o(done));
  initial forever #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [19:0] off, input logic [31:0] d);
    @(negedge clk_i);
    reg_addr_i = `DSC_BASE_A1 + off;
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    q = reg_rdata_o | rdata2;
    chk(reg_ack_o, 1);
  endtask
  task automatic rdc(input logic [19:0] off, input logic [31:0] e);
    acc(0, off, 0);
    chk(q, e);
  endtask
  function automatic dsc_size_t in_sz(logic [2:0] b);
    if (b == 0) return '{trans_hactive_i + seam_left_i + seam_right_i, pipe_src_h_i};
    return b <= 5 ? plane_size_i[b - 1] : '0;
  endfunction
  function automatic logic act();
    dsc_size_t s;
    s = in_sz(ctl[27:25]);
    return ctl[31] && ctl[27:25] <= 5 && s.w <= 5120 && s.h <= 4096;
  endfunction
  function automatic logic thru();
    return !act() || (ctl[24:23] == 0 && in_sz(ctl[27:25]) == {ww, wh} && !ctl[28]);
  endfunction
  function automatic dsc_pix_t exp_pix(dsc_pix_t p);
    if (act() && ctl[27:25] != 0 && (ix >= ww || iy >= wh)) p.a = '0;
    if (!thru() && ctl[27:25] != 0) begin
      p.r[1:0] = '0;
      p.g[1:0] = '0;
      p.b[1:0] = '0;
    end
    return p;
  endfunction
  // Settings only change while no pixel is in flight, so input-side prediction holds
  task automatic cfg(input logic [31:0] c, input logic [12:0] w, input logic [12:0] h);
    logic pa;
    pa = act();
    ctl = c & `DSC_CTRL_MASK;
    ww = w;
    wh = h;
    acc(1, `DSC_REL_CTRL, c);
    acc(1, `DSC_REL_WIN, {3'h0, w, 3'h0, h});
    acc(0, `DSC_REL_STAT, 0);
    chk(q[31:30], {pa, 1'b1});
    @(negedge clk_i);
    vblank_i = 1'b1;
    repeat (2) @(negedge clk_i);
    vblank_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic stat();
    dsc_size_t s;
    logic [1:0] ce;
    s = in_sz(ctl[27:25]);
    ce = ctl[28] ? {ctl[22], 1'b0} : ctl[24:23];
    acc(0, `DSC_REL_STAT, 0);
    chk({q[31:30], q[28]}, {act(), 1'b0, thru()});
    chk(q[27:23], {ctl[27:25], ce});
    if (ctl[27:25] <= 5) chk({q[12:0], cfg_o.in_size}, {s.w, s});
    chk({cfg_o.active, cfg_o.passthru, cfg_o.win_size}, {act(), thru(), ww, wh});
    chk({cfg_o.adaptive, cfg_o.thresholds}, {ctl[28] && act(), 24'hff_ffff});
    chk(cfg_o.tap_linear, ctl[21]);
  endtask
  always @(posedge clk_i) begin
    if (pix_valid_i && pix_ready_o) begin
      if (pix_i.sof) begin
        ix = 0;
        iy = 0;
      end
      expq.push_back(exp_pix(pix_i));
      inflight++;
      if (pix_i.eol) begin
        ix = 0;
        iy++;
      end else ix++;
    end
    if (pix_valid_o && pix_ready_i) begin
      chk(pix_o, expq.pop_front());
      inflight--;
    end
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    results();
  end
  initial begin
    plane_size_i = '{'{13'h8, 13'h8}, '{13'h8, 13'h8}, '{13'd5120, 13'd4096},
      '{13'd5121, 13'd4096}, '{13'd5120, 13'd4097}};
    ctl = '0;
    void'($urandom(31));
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    rdc(`DSC_REL_CTRL, `DSC_CTRL_RST);
    rdc(`DSC_REL_CIDX, 32'h400);
    rdc(`DSC_REL_WIN, 0);
    rdc(20'h00004, 0);
    acc(1, `DSC_BASE_A2 - `DSC_BASE_A1, '1);
    rdc(`DSC_BASE_A2 - `DSC_BASE_A1, `DSC_CTRL_MASK);
    rdc(`DSC_REL_CTRL, `DSC_CTRL_RST);
    acc(1, `DSC_REL_THR, '1);
    rdc(`DSC_REL_THR, `DSC_THR_MASK);
    acc(1, `DSC_REL_CTRL, '1);
    rdc(`DSC_REL_CTRL, `DSC_CTRL_MASK);
    acc(1, `DSC_REL_CIDX, 32'h43b);
    acc(1, `DSC_REL_CDAT, 32'h1234_5678);
    rdc(`DSC_REL_CIDX, 32'h400);
    acc(1, `DSC_REL_CIDX, 32'h3b);
    chk(coef_o, 32'h1234_5678);
    rdc(`DSC_REL_CDAT, 32'h1234_5678);
    rdc(`DSC_REL_CIDX, 32'h3b);
    for (int i = 0; i < 32; i++) begin
      logic [31:0] c;
      dsc_size_t s;
      c = $urandom;
      c[27:25] = 3'(i % 8);
      c[24:23] = 2'(i / 8);
      s = in_sz(c[27:25]);
      cfg(c, i % 3 ? 13'($urandom) : s.w, i % 3 ? 13'($urandom) : s.h);
      stat();
    end
    for (int f = 0; f < 4; f++) begin
      cfg(fc[f], f == 1 ? 13'h8 : 13'h6,
          f == 1 ? 13'h8 : 13'h5);
      stall = (f == 0);
      go = 1'b1;
      if (f == 0) begin
        repeat (30) @(negedge clk_i);
        chk(pix_ready_o, 0);
        chk(inflight, `DSC_FIFO_DEPTH);
        stall = 1'b0;
      end
      for (int k = 0; k < 2000 && (!done || inflight != 0); k++) @(negedge clk_i);
      chk({done, pix_valid_o}, 2'b10);
      go = 1'b0;
    end
    results();
  end
endmodule // display_pipe_scaler_control_bench
